// File: verilog/beab_params.svh
`ifndef BEAB_PARAMS_SVH
`define BEAB_PARAMS_SVH
// Address steps for early addressing
`define BEAB_STEP_SMALL   32'h0000_0004
`define BEAB_STEP_LARGE   32'h0000_0008
// Wrap block size is 1 Kbyte, so low ten bits roll over
`define BEAB_WRAP_BITS    10
`define BEAB_ADDR_BIT_A3  3
`define BEAB_ADDR_BIT_A2  2
`endif

// File: verilog/beab_pkg.sv
package beab_pkg;
   typedef enum logic [2:0] {
      BEAB_IDLE  = 3'b000,
      BEAB_FIRST = 3'b001,
      BEAB_NEXT  = 3'b010,
      BEAB_ERRGAP = 3'b011,
      BEAB_DONE  = 3'b100
   } beab_state_t;
   typedef logic [31:0] beab_addr_t;
endpackage

// File: verilog/beab_bus_if.sv
`timescale 1ns/100ps
// Shared bus between processor end and system end; pins active low where noted.
interface beab_bus_if;
   logic                 addrReqN;       // access request, low active
   logic                 addrReqOe;      // processor drives request
   logic                 sysReqN;        // request driven by external master
   logic                 sysReqOe;
   logic                 burstN;
   logic                 readyN;
   logic                 errorN;
   logic                 early_address_request;
   logic                 narrow_read_select;
   logic                 bus_request_out;  // low active grant-to-system role
   logic                 bus_grant_in;     // low active
   logic                 pageModeN;
   logic                 lockN;
   logic                 dataAccess;
   logic [31:0]          address;
   logic                 addressOe;
   wire                  reqLevelN = addrReqOe ? addrReqN : (sysReqOe ? sysReqN : 1'b1);
   modport proc (output addrReqN, addrReqOe, burstN, bus_request_out, pageModeN, lockN,
                 dataAccess, address, addressOe,
                 input readyN, errorN, early_address_request, narrow_read_select,
                 bus_grant_in, sysReqN, sysReqOe);
   modport sys  (input addrReqN, addrReqOe, burstN, bus_request_out, pageModeN, lockN,
                 dataAccess, address, addressOe,
                 output readyN, errorN, early_address_request, narrow_read_select,
                 bus_grant_in, sysReqN, sysReqOe);
endinterface

// File: verilog/beab_proc_end.sv
`timescale 1ns/100ps
`include "beab_params.svh"
// How it works
// R1 - Slave aborts burst with error plus ready
// R2 - After error, drop request and burst
// R3 - New request no sooner than second cycle
// R4 - Data error traps; fetch error may trap
// R5 - Early request in cycle two: next address
// R6 - Step eight when A3,A2 zero, else four
// R7 - First early address toggles A3 when aligned
// R8 - Ignore one cycle, then add eight
// R9 - Once early, advance only on request
// R10 - Wrap inside one Kbyte block
// R11 - Track current access address separately
// R12 - Ignore early for simple, narrow, 16-bit
// R13 - Request bus on load/store or miss
// R14 - Drive only after grant; else request high
// R15 - Unrequested grant usable next cycle
// R16 - Drop bus request after final ready
// R17 - Pre-emption: finish to stopping point
// R18 - Hold bus while lock active
// R19 - Resume multiple transfer where it stopped
// R20 - No page mode after regaining bus
// R21 - External master takes bus via grant removal
// R22 - External master drives request high first
// R23 - Burst marked in first cycle of access
// R24 - Ready sampled in first burst follow cycle
module beab_proc_end
   import beab_pkg::*;
(
   // Clock and reset
   input  wire logic           clk_sys,
   input  wire logic           resetn,
   // Bus
   beab_bus_if.proc            bus,
   // Core side
   input  wire logic           needBus,
   input  wire logic           startAccess,
   input  wire beab_pkg::beab_addr_t startAddr,
   input  wire logic [7:0]     wordCount,
   input  wire logic           isData,
   input  wire logic           bus16Wide,
   input  wire logic           lockReq,
   output logic                accessDone,
   output logic                dataTrap,
   output logic                instTrap,
   output beab_pkg::beab_addr_t currentAddr,
   output logic                busy
);
   import beab_pkg::*;
   beab_state_t  state_reg, state_next;
   beab_addr_t   addr_reg, cur_reg, nextAddr;
   logic [7:0]   left_reg;
   logic         early_reg, ignore_reg, data_reg, haveBus_reg, grantSeen_reg;
   logic         bus_request_out_reg, reqN_reg, burstN_reg, errGap_reg, pgN_reg, lock_reg;
   logic         dTrap_reg, iTrap_reg, done_reg, secondCyc_reg, stall_reg, cycTwo_reg;

   // ---------------------------------------------
   // Decode
   // ---------------------------------------------
   wire granted   = ~bus.bus_grant_in;
   wire active    = (state_reg == BEAB_FIRST) || (state_reg == BEAB_NEXT);
   wire rdySeen   = ~bus.readyN & (state_reg == BEAB_NEXT | ~secondCyc_reg);  // R24
   wire errSeen   = rdySeen & ~bus.errorN;                                     // R1
   wire lastWord  = (left_reg == 8'h01);
   wire earlyOk   = (left_reg > 8'h01) & ~bus.narrow_read_select & ~bus16Wide; // R12
   wire earlyHit  = earlyOk & bus.early_address_request & ~ignore_reg
                    & (early_reg | cycTwo_reg);                                 // R5 R9
   wire aligned   = ~addr_reg[`BEAB_ADDR_BIT_A3] & ~addr_reg[`BEAB_ADDR_BIT_A2];
   wire [31:0] step = aligned ? `BEAB_STEP_LARGE : `BEAB_STEP_SMALL;         // R6 R7
   wire [31:0] sum  = addr_reg + step;
   wire firstEarly = ~early_reg;
   wire [31:0] toggled = addr_reg ^ 32'h0000_0008;                            // R7
   wire [31:0] raw  = (firstEarly & aligned) ? toggled : sum;                 // R8
   // Keep upper bits so a step never leaves the 1 Kbyte block
   assign nextAddr = {addr_reg[31:`BEAB_WRAP_BITS], raw[`BEAB_WRAP_BITS-1:0]}; // R10
   wire preempt   = ~granted & ~lock_reg & ~stall_reg;                         // R17 R18
   wire mayStart  = haveBus_reg & startAccess & ~errGap_reg & (state_reg == BEAB_IDLE);
   wire stopNow   = rdySeen & preempt & (state_reg == BEAB_NEXT);                // R17
   wire finalRdy  = active & rdySeen & lastWord;                                 // R16

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         BEAB_IDLE:   if (mayStart) state_next = BEAB_FIRST;
         BEAB_FIRST:  if (errSeen) state_next = BEAB_ERRGAP;
                      else if (rdySeen) state_next = lastWord ? BEAB_DONE : BEAB_NEXT;
         BEAB_NEXT:   if (errSeen) state_next = BEAB_ERRGAP;                  // R2
                      else if (rdySeen & lastWord) state_next = BEAB_DONE;
                      else if (rdySeen & preempt) state_next = BEAB_IDLE;       // R19
         BEAB_ERRGAP: state_next = BEAB_IDLE;                                   // R3
         BEAB_DONE:   state_next = BEAB_IDLE;
         default:     state_next = BEAB_IDLE;
      endcase
   end

   // ---------------------------------------------
   // Sequencing
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_reg <= BEAB_IDLE;
         addr_reg  <= 32'h0000_0000;
         cur_reg   <= 32'h0000_0000;
         left_reg  <= 8'h00;
         early_reg <= 1'b0;
         ignore_reg <= 1'b0;
         secondCyc_reg <= 1'b0;
         cycTwo_reg <= 1'b0;
         data_reg  <= 1'b0;
         errGap_reg <= 1'b0;
         stall_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         errGap_reg <= errSeen;                                                 // R3
         secondCyc_reg <= mayStart | (rdySeen & active & ~lastWord);
         // Second cycle of the opening access, where early requests count
         cycTwo_reg <= secondCyc_reg & (state_reg == BEAB_FIRST);                // R5
         ignore_reg <= earlyHit & firstEarly;                                   // R8
         if (mayStart) begin
            addr_reg  <= startAddr;
            cur_reg   <= startAddr;
            left_reg  <= wordCount;
            data_reg  <= isData;
            early_reg <= 1'b0;
            stall_reg <= 1'b0;
         end else if (active & rdySeen & ~errSeen) begin
            left_reg <= left_reg - 8'h01;
            // Track current access; restart point survives pre-emption
            if (!lastWord) cur_reg <= cur_reg + `BEAB_STEP_SMALL;               // R11 R19
            if (!early_reg) addr_reg <= cur_reg + `BEAB_STEP_SMALL;
         end
         if (active & earlyHit) begin
            addr_reg  <= nextAddr;                                              // R5
            early_reg <= 1'b1;
         end
         if (errSeen | (state_reg == BEAB_DONE)) early_reg <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Arbitration and pins
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bus_request_out_reg    <= 1'b1;
         haveBus_reg <= 1'b0;
         grantSeen_reg <= 1'b0;
         reqN_reg    <= 1'b1;
         burstN_reg  <= 1'b1;
         pgN_reg     <= 1'b1;
         lock_reg    <= 1'b0;
         dTrap_reg   <= 1'b0;
         iTrap_reg   <= 1'b0;
         done_reg    <= 1'b0;
      end else begin
         lock_reg <= lockReq;
         grantSeen_reg <= granted;
         // Bus usable the cycle after grant seen, even unrequested
         haveBus_reg <= granted | (haveBus_reg & (active | lock_reg));          // R14 R15 R18
         // Request goes low with need; returns high once needBus is low and no access is in progress
         // Released bus is given up unless locked or mid-access
         bus_request_out_reg <= ~((needBus | (active & ~finalRdy & ~errSeen & ~stopNow) | mayStart)
                       & (granted | active | lock_reg));                        // R13 R16 R17
         reqN_reg   <= ~((mayStart) | (active & ~errSeen & ~finalRdy & ~stopNow)); // R2 R14
         burstN_reg <= ~((mayStart & (wordCount > 8'h01))
                       | (active & ~errSeen & ~stopNow & (left_reg > 8'h02)));  // R23
         // No page mode on first access after regaining bus
         pgN_reg    <= 1'b1;                                                     // R20
         dTrap_reg  <= errSeen & data_reg;                                      // R4
         iTrap_reg  <= errSeen & ~data_reg;                                     // R4
         done_reg   <= active & rdySeen & lastWord & ~errSeen;
      end
   end

   assign bus.addrReqN        = reqN_reg;
   assign bus.addrReqOe       = haveBus_reg;   // weak pullup modelled by interface default
   assign bus.burstN          = burstN_reg;
   assign bus.bus_request_out = bus_request_out_reg;
   assign bus.pageModeN       = pgN_reg;
   assign bus.lockN           = ~lock_reg;
   assign bus.dataAccess      = data_reg;
   assign bus.address         = addr_reg;
   assign bus.addressOe       = haveBus_reg;
   assign accessDone          = done_reg;
   assign dataTrap            = dTrap_reg;
   assign instTrap            = iTrap_reg;
   assign currentAddr         = cur_reg;
   assign busy                = haveBus_reg;
endmodule

// File: verilog/beab_sys_end.sv
`timescale 1ns/100ps
`include "beab_params.svh"
module beab_sys_end
   import beab_pkg::*;
(
   // Clock and reset
   input  wire logic   clk_sys,
   input  wire logic   resetn,
   // Bus
   beab_bus_if.sys     bus,
   // User side
   input  wire logic   wantBus,
   input  wire logic   abortBurst,
   input  wire logic   useEarly,
   input  wire logic   narrowSel,
   input  wire logic   slowSlave,
   output logic        ownsBus,
   output logic        answered
);
   import beab_pkg::*;
   logic grantN_reg, own_reg, rdyN_reg, errN_reg, early_reg, drvHigh_reg, oe_reg;
   logic second_reg, ans_reg, narrow_reg;

   wire reqActive = ~bus.addrReqN & bus.addrReqOe;
   wire procOff   = bus.bus_request_out;
   // Ready only in cycle two onward; a slow slave waits one cycle more
   wire giveRdy   = reqActive & rdyN_reg & (~slowSlave | second_reg);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         grantN_reg  <= 1'b0;
         own_reg     <= 1'b0;
         rdyN_reg    <= 1'b1;
         errN_reg    <= 1'b1;
         early_reg   <= 1'b0;
         drvHigh_reg <= 1'b0;
         oe_reg      <= 1'b0;
         second_reg  <= 1'b0;
         ans_reg     <= 1'b0;
         narrow_reg  <= 1'b0;
      end else begin
         narrow_reg <= narrowSel;
         // Take bus by removing grant, wait for request to go high
         grantN_reg <= wantBus;                                                  // R21
         own_reg    <= wantBus & grantN_reg & procOff;
         // Drive request high one cycle before floating it
         drvHigh_reg <= own_reg & ~wantBus;                                      // R22
         oe_reg      <= own_reg | (own_reg & ~wantBus);
         rdyN_reg   <= ~giveRdy;                                                 // R24
         errN_reg   <= ~(giveRdy & abortBurst & ~bus.burstN);                    // R1
         second_reg <= reqActive & ~second_reg & rdyN_reg;
         early_reg  <= useEarly & reqActive & ~bus.burstN;                       // R5 R9
         ans_reg    <= giveRdy;
      end
   end

   assign bus.bus_grant_in          = grantN_reg;
   assign bus.readyN                = rdyN_reg;
   assign bus.errorN                = errN_reg;
   assign bus.early_address_request = early_reg;
   assign bus.narrow_read_select    = narrow_reg;
   assign bus.sysReqN               = 1'b1;
   assign bus.sysReqOe              = oe_reg;
   assign ownsBus                   = own_reg;
   assign answered                  = ans_reg;
endmodule

// File: sim/beab_bus_properties.sv
`timescale 1ns/100ps
module beab_bus_properties (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        resetn,
   // Bus signals
   input wire logic        addrReqN,
   input wire logic        addrReqOe,
   input wire logic        burstN,
   input wire logic        readyN,
   input wire logic        errorN,
   input wire logic        early_address_request,
   input wire logic        bus_request_out,
   input wire logic        bus_grant_in,
   input wire logic        pageModeN,
   input wire logic        lockN,
   input wire logic [31:0] address
);
   // ------------------------------
   // Properties
   // ------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire errHit = !addrReqN && !readyN && !errorN;
   a_err_burst_drop: assert property (errHit |=> burstN && addrReqN)
      else $error("request or burst still low after error");
   a_early_in_block: assert property ((!addrReqN && early_address_request) |=>
      addrReqN || address[31:10] == $past(address[31:10]))
      else $error("early address left its block");
   a_grant_before_drive: assert property ($rose(addrReqOe) |-> $past(!bus_grant_in))
      else $error("bus driven without grant");
   a_bus_request_out_with_req: assert property ((addrReqOe && !addrReqN) |-> !bus_request_out)
      else $error("request driven without bus request");
   a_bus_request_out_after_ready: assert property (($rose(bus_request_out) && $past(!addrReqN)) |->
      $past(!readyN))
      else $error("bus request dropped before final ready");
   a_lock_keeps_bus: assert property ((!lockN && !bus_request_out) |=> !bus_request_out)
      else $error("bus released under lock");
   a_burst_needs_req: assert property (!burstN |-> !addrReqN)
      else $error("burst flag without request");
   a_no_page_first: assert property ((!addrReqN && $rose(addrReqOe)) |-> pageModeN)
      else $error("page mode on first access after grant");
   c_error: cover property (errHit);
   c_early: cover property (!addrReqN && early_address_request);
   c_release: cover property ($rose(bus_request_out));
endmodule

// File: sim/burst_early_address_and_bus_arbitration_tb.sv
`timescale 1ns/100ps
module burst_early_address_and_bus_arbitration_tb;
   import beab_pkg::*;
   // ------------------------------
   // Stimulus and checks
   // ------------------------------
   typedef struct packed {
      beab_addr_t a; logic [7:0] n; logic d, e, nr, w, ab, sl;
   } beab_row_t;
   // Fields: addr, words, data, early, narrow, 16-bit, abort, slow
   localparam beab_row_t ROWS [8] = '{
      '{32'h0000_0100, 8'h04, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
      '{32'h0000_0200, 8'h04, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0000_0300, 8'h04, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
      '{32'h0000_0400, 8'h04, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
      '{32'h0000_07F0, 8'h04, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0000_0900, 8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
      '{32'h0000_0500, 8'h04, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
      '{32'h0000_0600, 8'h08, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0}};
   logic       clk_sys = 1'b0, resetn = 1'b0, needBus = 1'b0, startAccess = 1'b0;
   logic       isData = 1'b0, bus16Wide = 1'b0, lockReq = 1'b0, wantBus = 1'b0;
   logic       abortBurst = 1'b0, useEarly = 1'b0, narrowSel = 1'b0, slowSlave = 1'b0;
   logic [7:0] wordCount = 8'h00;
   logic       accessDone, dataTrap, instTrap, busy, ownsBus, seen = 1'b0;
   beab_addr_t startAddr = 32'h0000_0000, currentAddr, rowA, rowF;
   int         num_errors = 0, checked = 0;
   always #5 clk_sys = ~clk_sys;
   beab_bus_if bus ();
   beab_proc_end i_beab_proc_end (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
      .needBus(needBus), .startAccess(startAccess), .startAddr(startAddr),
      .wordCount(wordCount), .isData(isData), .bus16Wide(bus16Wide), .lockReq(lockReq),
      .accessDone(accessDone), .dataTrap(dataTrap), .instTrap(instTrap),
      .currentAddr(currentAddr), .busy(busy));
   beab_sys_end i_beab_sys_end (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
      .wantBus(wantBus), .abortBurst(abortBurst), .useEarly(useEarly), .narrowSel(narrowSel),
      .slowSlave(slowSlave), .ownsBus(ownsBus), .answered());
   beab_bus_properties i_beab_bus_properties (.clk_sys(clk_sys), .resetn(resetn),
      .addrReqN(bus.addrReqN), .addrReqOe(bus.addrReqOe), .burstN(bus.burstN),
      .readyN(bus.readyN), .errorN(bus.errorN), .early_address_request(bus.early_address_request),
      .bus_request_out(bus.bus_request_out), .bus_grant_in(bus.bus_grant_in),
      .pageModeN(bus.pageModeN), .lockN(bus.lockN), .address(bus.address));
   // First early address seen while the second word is in flight
   always @(posedge clk_sys)
      if (!bus.addrReqN && bus.address === rowF && currentAddr === rowA + 32'h0000_0004)
         seen = 1'b1;
   task automatic chk_bit(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic chk_addr(input string nm, input beab_addr_t e, input beab_addr_t g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic end_of_test;
      if (num_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return busy;
         1: return accessDone | dataTrap | instTrap;
         default: return ownsBus;
      endcase
   endfunction
   // Bounded wait; a hang is counted and ends the run
   task automatic wait_for(input int s, input logic v);
      int k;
      for (k = 0; k < 300 && pick(s) !== v; k++) @(posedge clk_sys);
      if (pick(s) !== v) begin
         num_errors++;
         end_of_test();
      end
   endtask
   task automatic run_row(input beab_row_t r);
      @(posedge clk_sys);
      abortBurst <= r.ab;
      useEarly <= r.e;
      narrowSel <= r.nr;
      slowSlave <= r.sl;
      bus16Wide <= r.w;
      startAddr <= r.a;
      wordCount <= r.n;
      isData <= r.d;
      startAccess <= 1'b1;
      rowA = r.a;
      rowF = (r.a[3:2] == 2'b00) ? (r.a ^ 32'h0000_0008) : (r.a + 32'h0000_0004);
      seen = 1'b0;
      @(posedge clk_sys);
      startAccess <= 1'b0;
      wait_for(1, 1'b1);
      chk_bit("accessDone", !r.ab, accessDone);
      chk_bit("dataTrap", r.ab & r.d, dataTrap);
      if (!r.ab && !r.nr && !r.w)
         chk_addr("currentAddr", r.a + beab_addr_t'({r.n - 8'h01, 2'b00}), currentAddr);
      chk_bit("earlyAddr", r.e & !r.nr & !r.w & (r.n > 8'h01), seen);
      // Error gap is one cycle (BEAB_ERRGAP), so two more cycles clear it before the next start
      repeat (2) @(posedge clk_sys);
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      chk_bit("breqReset", 1'b1, bus.bus_request_out);
      chk_bit("reqReset", 1'b1, bus.reqLevelN);
      resetn <= 1'b1;
      needBus <= 1'b1;
      wait_for(0, 1'b1);
      foreach (ROWS[i]) run_row(ROWS[i]);
      // Pre-emption under lock, then released, then regained
      lockReq <= 1'b1;
      wantBus <= 1'b1;
      run_row(ROWS[0]);
      chk_bit("ownsBusLocked", 1'b0, ownsBus);
      lockReq <= 1'b0;
      wait_for(2, 1'b1);
      chk_bit("busyReleased", 1'b0, busy);
      wantBus <= 1'b0;
      wait_for(0, 1'b1);
      run_row(ROWS[1]);
      needBus <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk_bit("busyGranted", 1'b1, busy);
      chk_bit("breqIdle", 1'b1, bus.bus_request_out);
      end_of_test();
   end
endmodule
